// >>> src/dcad_defs.vh
// shared constants for the ddr4 command/address decoder
`ifndef DCAD_DEFS_VH
`define DCAD_DEFS_VH

// command codes presented on cmd_code
`define DCAD_CMD_NOP    4'h0
`define DCAD_CMD_ACT    4'h1
`define DCAD_CMD_RD     4'h2
`define DCAD_CMD_WR     4'h3
`define DCAD_CMD_PRE    4'h4
`define DCAD_CMD_REF    4'h5
`define DCAD_CMD_MRS    4'h6
`define DCAD_CMD_ZQC    4'h7
`define DCAD_CMD_DES    4'h8
`define DCAD_CMD_RSV    4'h9
`define DCAD_CMD_SRE    4'hA

// data width configurations on cfg_width
`define DCAD_W_X4       2'h0
`define DCAD_W_X8       2'h1
`define DCAD_W_X16      2'h2

// stack height on cfg_stack
`define DCAD_STK_1H     2'h0
`define DCAD_STK_2H     2'h1
`define DCAD_STK_4H     2'h2
`define DCAD_STK_8H     2'h3

// power states
`define DCAD_PS_ACTIVE  2'h0
`define DCAD_PS_PPD     2'h1
`define DCAD_PS_APD     2'h2
`define DCAD_PS_SR      2'h3

// address field positions
`define DCAD_A_AP       10
`define DCAD_A_BC       12
`define DCAD_A_TOP      17
`define DCAD_COL_W      10

`endif

// >>> src/dcad_sync.v
// two-stage synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none

module dcad_sync #(
  parameter WIDTH = 1
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> src/dcad_decode.v
// ddr4 command, address and clock-enable decode, device side
// Notes on behaviour
// - activate takes row address, read and write take column address
// - mode register set passes address inputs as the opcode
// - top address bit A17 used only in x4, else forced zero
// - A10 on read or write requests auto precharge
// - precharge with A10 high hits all banks, else one bank
// - A12 low on read or write chops the burst
// - activate strobe with select makes an activate, high pins become row bits
// - bank address picks the bank and helps pick the mode register
// - bank group picks the group and helps pick the mode register
// - two bank group bits in x4 and x8, one bit in x16; cmd_mr_sel still takes both bits in x16
// - chip id decoded for 2, 4 or 8 high stacks in x4 and x8
// - chip id unused in x16 and in unstacked parts
// - inputs sampled on rising edge of the true clock
// - clock enable high enables clocks and buffers, low disables them
// - enable low enters precharge power-down or self refresh, or active power-down
// - self refresh exit seen from enable without the link clock
// - power-down keeps only clock, termination, reset and enable buffers
// - self refresh keeps only enable and reset buffers
// - commands ignored while chip select is high
// - with activate strobe high, three pins code the command
// - reset acts asynchronously while low
`timescale 1ns/1ns
`default_nettype none
`include "dcad_defs.vh"

module dcad_decode #(
  parameter ROW_W = 18,
  parameter NUM_BANKS = 16,
  parameter [2:0] DIE_ID = 3'h0
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [1:0] cfg_width,
  input wire [1:0] cfg_stack,
  input wire ck_t,
  input wire ck_c,
  input wire cke,
  input wire cs_n,
  input wire act_n,
  input wire ras_n_a16,
  input wire cas_n_a15,
  input wire we_n_a14,
  input wire [1:0] bg,
  input wire [1:0] ba,
  input wire [13:0] addr,
  input wire a17,
  input wire [2:0] chip_id,
  input wire odt,
  output reg cmd_valid,
  output reg [3:0] cmd_code,
  output reg [1:0] cmd_bg,
  output reg [1:0] cmd_ba,
  output reg [ROW_W-1:0] cmd_row,
  output reg [`DCAD_COL_W-1:0] cmd_col,
  output reg cmd_auto_pre,
  output reg cmd_burst_chop,
  output reg cmd_pre_all,
  output reg [3:0] cmd_mr_sel,
  output reg [ROW_W-1:0] cmd_opcode,
  output reg [1:0] pwr_state,
  output reg clk_en_int,
  output reg buf_en_cmd,
  output reg buf_en_ck,
  output reg odt_int
);

  // ==========================================================
  // input synchronisation
  // ==========================================================
  wire [29:0] raw_in;
  wire [29:0] s_in;
  assign raw_in = {ck_t, ck_c, cs_n, act_n, ras_n_a16, cas_n_a15,
                   we_n_a14, bg, ba, addr, a17, chip_id, odt};

  dcad_sync #(
    .WIDTH(30)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(raw_in),
    .dout(s_in)
  );

  // cke gets its own path so the sync is never gated by buffer state
  reg cke_m;
  reg cke_s;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_m <= 1'b0;
      cke_s <= 1'b0;
    end else begin
      cke_m <= cke;
      cke_s <= cke_m;
    end
  end

  wire s_ckt = s_in[29];
  wire s_ckc = s_in[28];
  wire s_cs_n = s_in[27];
  wire s_act_n = s_in[26];
  wire s_ras = s_in[25];
  wire s_cas = s_in[24];
  wire s_we = s_in[23];
  wire [1:0] s_bg = s_in[22:21];
  wire [1:0] s_ba = s_in[20:19];
  wire [13:0] s_addr = s_in[18:5];
  wire s_a17 = s_in[4];
  wire [2:0] s_cid = s_in[3:1];
  wire s_odt = s_in[0];

  // ==========================================================
  // link clock edge detection
  // ==========================================================
  reg ckt_d;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckt_d <= 1'b0;
    end else begin
      ckt_d <= s_ckt;
    end
  end
  // true clock rising while complement is low marks the sample point
  wire ck_rise = s_ckt & ~ckt_d & ~s_ckc;

  // ==========================================================
  // power state machine
  // ==========================================================
  localparam [1:0] ST_ACT = `DCAD_PS_ACTIVE;
  localparam [1:0] ST_PPD = `DCAD_PS_PPD;
  localparam [1:0] ST_APD = `DCAD_PS_APD;
  localparam [1:0] ST_SR = `DCAD_PS_SR;

  reg [NUM_BANKS-1:0] bank_open;
  reg [1:0] next_pwr;
  reg [3:0] cmd_now;
  wire any_open = |bank_open;
  wire sel_ok;

  always @* begin
    next_pwr = pwr_state;
    case (pwr_state)
      ST_ACT: begin
        if (!cke_s && ck_rise) begin
          if (any_open) begin
            next_pwr = ST_APD;
          end else if (sel_ok && cmd_now == `DCAD_CMD_REF) begin
            next_pwr = ST_SR;
          end else begin
            next_pwr = ST_PPD;
          end
        end
      end
      ST_PPD, ST_APD: begin
        if (cke_s && ck_rise) begin
          next_pwr = ST_ACT;
        end
      end
      ST_SR: begin
        // no clock needed, enable alone wakes the part
        if (cke_s) begin
          next_pwr = ST_ACT;
        end
      end
      default: begin
        next_pwr = ST_ACT;
      end
    endcase
  end

  // ==========================================================
  // command truth table
  // ==========================================================
  reg cid_ok;
  always @* begin
    // x16 and single die ignore chip id entirely
    if (cfg_width == `DCAD_W_X16 || cfg_stack == `DCAD_STK_1H) begin
      cid_ok = 1'b1;
    end else begin
      case (cfg_stack)
        `DCAD_STK_2H: cid_ok = (s_cid[0] == DIE_ID[0]);
        `DCAD_STK_4H: cid_ok = (s_cid[1:0] == DIE_ID[1:0]);
        `DCAD_STK_8H: cid_ok = (s_cid == DIE_ID);
        default: cid_ok = 1'b1;
      endcase
    end
  end

  assign sel_ok = ~s_cs_n & cid_ok;

  always @* begin
    if (!sel_ok) begin
      cmd_now = `DCAD_CMD_DES;
    end else if (!s_act_n) begin
      cmd_now = `DCAD_CMD_ACT;
    end else begin
      case ({s_ras, s_cas, s_we})
        3'h0: cmd_now = `DCAD_CMD_MRS;
        3'h1: cmd_now = `DCAD_CMD_REF;
        3'h2: cmd_now = `DCAD_CMD_PRE;
        3'h3: cmd_now = `DCAD_CMD_RSV;
        3'h4: cmd_now = `DCAD_CMD_WR;
        3'h5: cmd_now = `DCAD_CMD_RD;
        3'h6: cmd_now = `DCAD_CMD_ZQC;
        3'h7: cmd_now = `DCAD_CMD_NOP;
        default: cmd_now = `DCAD_CMD_NOP;
      endcase
    end
  end

  // ==========================================================
  // address assembly
  // ==========================================================
  wire top_bit = (cfg_width == `DCAD_W_X4) ? s_a17 : 1'b0;
  wire [1:0] bg_eff = (cfg_width == `DCAD_W_X16) ?
                      {1'b0, s_bg[0]} : s_bg;
  wire [ROW_W-1:0] row_full;
  assign row_full = {top_bit, s_ras, s_cas, s_we, s_addr};
  wire [ROW_W-1:0] opc_full;
  // pins A14 to A16 act as command bits in a set and A17 is not passed, so all four read as zero
  assign opc_full = {4'h0, s_addr};
  wire [3:0] bank_idx = {bg_eff, s_ba};

  // gated clocks: commands only move while in active state with enable
  wire live = (pwr_state == ST_ACT) & cke_s & ck_rise;

  // ==========================================================
  // registered outputs and bank tracking
  // ==========================================================
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= ST_ACT;
      bank_open <= {NUM_BANKS{1'b0}};
      cmd_valid <= 1'b0;
      cmd_code <= `DCAD_CMD_NOP;
      cmd_bg <= 2'h0;
      cmd_ba <= 2'h0;
      cmd_row <= {ROW_W{1'b0}};
      cmd_col <= {`DCAD_COL_W{1'b0}};
      cmd_auto_pre <= 1'b0;
      cmd_burst_chop <= 1'b0;
      cmd_pre_all <= 1'b0;
      cmd_mr_sel <= 4'h0;
      cmd_opcode <= {ROW_W{1'b0}};
      clk_en_int <= 1'b0;
      buf_en_cmd <= 1'b0;
      buf_en_ck <= 1'b0;
      odt_int <= 1'b0;
    end else begin
      pwr_state <= next_pwr;
      clk_en_int <= (next_pwr == ST_ACT);
      buf_en_cmd <= (next_pwr == ST_ACT);
      buf_en_ck <= (next_pwr != ST_SR);
      // termination buffer stays up in power-down, drops in self refresh
      odt_int <= (next_pwr != ST_SR) ? s_odt : 1'b0;
      cmd_valid <= live && cmd_now != `DCAD_CMD_DES &&
                   cmd_now != `DCAD_CMD_NOP;
      if (live && cmd_now != `DCAD_CMD_DES) begin
        cmd_code <= cmd_now;
        cmd_bg <= bg_eff;
        cmd_ba <= s_ba;
        cmd_auto_pre <= 1'b0;
        cmd_burst_chop <= 1'b0;
        cmd_pre_all <= 1'b0;
        case (cmd_now)
          `DCAD_CMD_ACT: begin
            cmd_row <= row_full;
            bank_open[bank_idx] <= 1'b1;
          end
          `DCAD_CMD_RD, `DCAD_CMD_WR: begin
            cmd_col <= s_addr[`DCAD_COL_W-1:0];
            cmd_auto_pre <= s_addr[`DCAD_A_AP];
            cmd_burst_chop <= ~s_addr[`DCAD_A_BC];
            if (s_addr[`DCAD_A_AP]) begin
              bank_open[bank_idx] <= 1'b0;
            end
          end
          `DCAD_CMD_PRE: begin
            cmd_pre_all <= s_addr[`DCAD_A_AP];
            if (s_addr[`DCAD_A_AP]) begin
              bank_open <= {NUM_BANKS{1'b0}};
            end else begin
              bank_open[bank_idx] <= 1'b0;
            end
          end
          `DCAD_CMD_MRS: begin
            cmd_mr_sel <= {s_bg, s_ba};
            cmd_opcode <= opc_full;
          end
          default: begin
            cmd_row <= cmd_row;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb/dcad_ctrl_model.sv
// controller model driving the command and address pins
`timescale 1ns/1ns
`default_nettype none
// ==========
// model
module dcad_ctrl_model (
  input wire logic sys_clk,
  output logic ck_t,
  output logic ck_c,
  output logic cke,
  output logic cs_n,
  output logic act_n,
  output logic ras_n_a16,
  output logic cas_n_a15,
  output logic we_n_a14,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [13:0] addr,
  output logic a17,
  output logic [2:0] chip_id,
  output logic odt
);
  initial begin
    {ck_t, ck_c, cke, cs_n, act_n, odt} = 6'h1F;
    {ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr, a17, chip_id} = 25'h0;
  end
  // one command per link clock; clock stands still between frames
  task frame(input [27:0] v, input integer gap);
    begin
      @(negedge sys_clk);
      {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = v[27:22];
      {bg, ba, addr, a17, chip_id} = v[21:0];
      odt = ~odt;
      repeat (4) @(negedge sys_clk);
      {ck_t, ck_c} = 2'b10;
      repeat (4) @(negedge sys_clk);
      {ck_t, ck_c} = 2'b01;
      // chip select goes high and the other released pins show the inverse, never a stale copy
      {cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = ~{1'b0, v[25:22]};
      {bg, ba, addr, a17, chip_id} = ~v[21:0];
      repeat (2 + gap) @(negedge sys_clk);
    end
  endtask
  task wake();
    begin
      @(negedge sys_clk);
      cke = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/dcad_asserts.sv
// assertion checker for the command decoder
`timescale 1ns/1ns
`default_nettype none
`include "dcad_defs.vh"
// ==========
// checker
module dcad_asserts #(
  parameter ROW_W = 18
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [1:0] cfg_width,
  input wire ck_t,
  input wire ck_c,
  input wire cke,
  input wire cs_n,
  input wire odt,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [1:0] cmd_bg,
  input wire [ROW_W-1:0] cmd_row,
  input wire [1:0] pwr_state,
  input wire clk_en_int,
  input wire buf_en_cmd,
  input wire buf_en_ck,
  input wire odt_int
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sr_wake;
    (pwr_state == `DCAD_PS_SR) ##0 $rose(cke);
  endsequence
  sequence s_awake;
    ##[1:6] (pwr_state == `DCAD_PS_ACTIVE);
  endsequence
  a_sr_exit: assert property (s_sr_wake |-> s_awake)
    else $error("self refresh not left on enable");
  a_pulse_code: assert property (cmd_valid |->
    cmd_code != `DCAD_CMD_NOP && cmd_code != `DCAD_CMD_DES)
    else $error("pulse on a no-operation");
  a_cs_masks: assert property (cmd_valid |-> !$past(cs_n, 3))
    else $error("command taken while deselected");
  a_ck_sample: assert property (cmd_valid |->
    $past(ck_t, 3) && !$past(ck_c, 3))
    else $error("command not at a clock crossing");
  a_row_top: assert property (cmd_valid && cmd_code == `DCAD_CMD_ACT &&
    cfg_width != `DCAD_W_X4 |-> !cmd_row[ROW_W-1])
    else $error("top row bit used outside x4");
  a_bg_single: assert property (cmd_valid &&
    cfg_width == `DCAD_W_X16 |-> !cmd_bg[1])
    else $error("second group bit used in x16");
  a_sr_bufs: assert property (pwr_state == `DCAD_PS_SR |->
    !buf_en_ck && !odt_int && !clk_en_int)
    else $error("buffers live in self refresh");
  a_pd_bufs: assert property ((pwr_state == `DCAD_PS_PPD ||
    pwr_state == `DCAD_PS_APD) |-> !buf_en_cmd && buf_en_ck)
    else $error("wrong buffers in power-down");
  a_active_en: assert property ((pwr_state == `DCAD_PS_ACTIVE) [*2] |->
    clk_en_int && buf_en_cmd)
    else $error("clocks off while active");
  // termination input passes through two sync stages and one register
  a_odt_pass: assert property ($past(rst_n, 4) &&
    pwr_state != `DCAD_PS_SR |-> odt_int == $past(odt, 3))
    else $error("termination not passed outside self refresh");
endmodule
bind dcad_decode dcad_asserts #(.ROW_W(ROW_W)) chk (.sys_clk, .rst_n,
  .cfg_width, .ck_t, .ck_c, .cke, .cs_n, .odt, .cmd_valid, .cmd_code, .cmd_bg,
  .cmd_row, .pwr_state, .clk_en_int, .buf_en_cmd, .buf_en_ck, .odt_int);
`default_nettype wire

// >>> tb/test_ddr4_cmd_addr_decode.sv
// self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
`include "dcad_defs.vh"
// ==========
// bench
module test_ddr4_cmd_addr_decode;
  logic sys_clk, rst_n, quiet;
  logic [1:0] cfg_width, cfg_stack;
  wire ck_t, ck_c, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14;
  wire a17, odt, cmd_valid, cmd_auto_pre, cmd_burst_chop, cmd_pre_all;
  wire clk_en_int, buf_en_cmd, buf_en_ck, odt_int;
  wire [1:0] bg, ba, cmd_bg, cmd_ba, pwr_state;
  wire [13:0] addr;
  wire [2:0] chip_id;
  wire [3:0] cmd_code, cmd_mr_sel;
  wire [17:0] cmd_row, cmd_opcode;
  wire [9:0] cmd_col;
  logic [39:0] q[$];
  logic [31:0] r;
  logic [15:0] seed;
  integer fail_count, checked, i, ph;
  dcad_ctrl_model ctl (.sys_clk, .ck_t, .ck_c, .cke, .cs_n, .act_n,
    .ras_n_a16, .cas_n_a15, .we_n_a14, .bg, .ba, .addr, .a17, .chip_id, .odt);
  dcad_decode uut (.sys_clk, .rst_n, .cfg_width, .cfg_stack, .ck_t, .ck_c,
    .cke, .cs_n, .act_n, .ras_n_a16, .cas_n_a15, .we_n_a14, .bg, .ba, .addr,
    .a17, .chip_id, .odt, .cmd_valid, .cmd_code, .cmd_bg, .cmd_ba, .cmd_row,
    .cmd_col, .cmd_auto_pre, .cmd_burst_chop, .cmd_pre_all, .cmd_mr_sel,
    .cmd_opcode, .pwr_state, .clk_en_int, .buf_en_cmd, .buf_en_ck, .odt_int);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input [39:0] g, input [39:0] e);
    begin
      checked++;
      if (g !== e) begin
        fail_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task summarize();
    begin
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // frame bits: cke cs act ras cas we bg ba addr a17 chip
  function automatic [39:0] expect_of(input [27:0] v);
    logic [1:0] g;
    logic [13:0] a;
    begin
      g = (cfg_width == `DCAD_W_X16) ? {1'b0, v[20]} : v[21:20];
      a = v[17:4];
      if (!v[25])
        expect_of = {`DCAD_CMD_ACT, 14'h0, g, v[19:18],
          (cfg_width == `DCAD_W_X4) & v[3], v[24:22], a};
      else case (v[24:22])
        3'h0: expect_of = {`DCAD_CMD_MRS, 14'h0, v[21:18], 4'h0, a};
        3'h1: expect_of = {`DCAD_CMD_REF, 36'h0};
        3'h2: expect_of = {`DCAD_CMD_PRE, 31'h0,
          a[10] ? 4'h0 : {g, v[19:18]}, a[10]};
        3'h3: expect_of = {`DCAD_CMD_RSV, 36'h0};
        3'h4, 3'h5: expect_of = {v[22] ? `DCAD_CMD_RD : `DCAD_CMD_WR,
          20'h0, g, v[19:18], a[10], ~a[12], a[9:0]};
        3'h6: expect_of = {`DCAD_CMD_ZQC, 36'h0};
        default: expect_of = 40'h0;
      endcase
    end
  endfunction
  function automatic [39:0] got_of();
    case (cmd_code)
      `DCAD_CMD_ACT: got_of = {cmd_code, 14'h0, cmd_bg, cmd_ba, cmd_row};
      `DCAD_CMD_MRS: got_of = {cmd_code, 14'h0, cmd_mr_sel, cmd_opcode};
      `DCAD_CMD_PRE: got_of = {cmd_code, 31'h0,
        cmd_pre_all ? 4'h0 : {cmd_bg, cmd_ba}, cmd_pre_all};
      `DCAD_CMD_RD, `DCAD_CMD_WR: got_of = {cmd_code, 20'h0, cmd_bg, cmd_ba,
        cmd_auto_pre, cmd_burst_chop, cmd_col};
      default: got_of = {cmd_code, 36'h0};
    endcase
  endfunction
  task send(input [27:0] v, input integer gap);
    begin
      // deselected, powered down or foreign die: nothing expected
      if (v[27] && !v[26] && expect_of(v) !== 40'h0 && (cfg_stack == 0 ||
          cfg_width == `DCAD_W_X16 || !v[0]))
        q.push_back(expect_of(v));
      ctl.frame(v, gap);
    end
  endtask
  always @(posedge sys_clk)
    if (cmd_valid === 1'b1 && !quiet)
      chk(got_of(), q.size() ? q.pop_front() : 40'hFFFFFFFFFF);
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    {fail_count, checked, quiet, rst_n} = 0;
    seed = 16'h0033;
    {cfg_width, cfg_stack} = 4'h0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (ph = 0; ph < 3; ph++) begin
      cfg_width = ph[1] ? `DCAD_W_X16 : `DCAD_W_X4;
      cfg_stack = ph ? `DCAD_STK_2H : `DCAD_STK_1H;
      for (i = 0; i < 27; i++) begin
        seed = lfsr(seed);
        r[15:0] = seed;
        seed = lfsr(seed);
        r[31:16] = seed;
        r[21] = r[21] & (i % 9 != 0 || ph != 2);
        send({2'b10, i % 9 == 8 ? {1'b0, r[24:22]} : {1'b1, 3'(i % 9)},
          r[21:0]} | {1'b0, r[26] & (i > 9), 26'h0}, r[31:30]);
      end
      $display("test commands phase %0d done", ph);
    end
    cfg_width = `DCAD_W_X4;
    cfg_stack = `DCAD_STK_1H;
    send({6'b101010, 22'h004000}, 0);
    send({6'b001111, 22'h0}, 0);
    chk({37'h0, pwr_state, buf_en_cmd}, {37'h0, `DCAD_PS_PPD, 1'b0});
    send({6'b000000, 22'h0}, 0);
    send({6'b101111, 22'h0}, 0);
    send({6'b100000, 22'h0}, 0);
    send({6'b001111, 22'h0}, 0);
    chk({38'h0, pwr_state}, {38'h0, `DCAD_PS_APD});
    send({6'b101111, 22'h0}, 0);
    send({6'b101010, 22'h004000}, 0);
    quiet = 1'b1;
    send({6'b001001, 22'h0}, 0);
    chk({37'h0, pwr_state, buf_en_ck}, {37'h0, `DCAD_PS_SR, 1'b0});
    ctl.wake();
    repeat (8) @(negedge sys_clk);
    chk({38'h0, pwr_state}, {38'h0, `DCAD_PS_ACTIVE});
    quiet = 1'b0;
    $display("test power states done");
    chk(40'(q.size()), 40'h0);
    summarize();
  end
endmodule
`default_nettype wire
